/* hdl/gtp_map.svh */
// Register offsets, field positions and reset values of the contact-input and tally port block.
`ifndef GTP_MAP_SVH
`define GTP_MAP_SVH

`define GTP_KEYS 4
`define GTP_KEY_W 2

`define GTP_ADDR_W 8
`define GTP_CFG_BASE 8'h00
`define GTP_STAT_OFF 8'h40
`define GTP_LVL_LSB 16

`define GTP_CFG_W 13
`define GTP_CFG_RST 13'h0000
`define GTP_IFN_LSB 0
`define GTP_IFN_MSB 2
`define GTP_TRIG_BIT 3
`define GTP_IPOL_BIT 4
`define GTP_IKEY_LSB 5
`define GTP_IKEY_MSB 6
`define GTP_TFN_LSB 7
`define GTP_TFN_MSB 9
`define GTP_TPOL_BIT 10
`define GTP_TKEY_LSB 11
`define GTP_TKEY_MSB 12

`define GTP_RESP_OKAY 2'h0
`define GTP_RESP_SLVERR 2'h2

`endif

/* hdl/gtp_pkg.sv */
// Types shared by the contact-input and tally port block.
`include "gtp_map.svh"

package gtp_pkg;

    typedef enum logic [2:0] {
        IN_NONE,
        IN_BG_CUT,
        IN_BG_AUTO,
        IN_KEY_CUT,
        IN_KEY_AUTO,
        IN_FADE_BLACK,
        IN_TIMECODE
    } gtp_in_fn_t;

    typedef enum logic [2:0] {
        TAL_NONE,
        TAL_BG_A,
        TAL_BG_B,
        TAL_EXT_KEY,
        TAL_EXT_ALPHA,
        TAL_KEY,
        TAL_ANY_KEY
    } gtp_tally_fn_t;

    typedef struct packed {
        logic bg_a;
        logic bg_b;
        logic ext_key;
        logic ext_alpha;
        logic [`GTP_KEYS-1:0] key;
    } gtp_on_air_t;

    typedef struct packed {
        logic bg_cut;
        logic bg_auto;
        logic fade_black;
        logic [`GTP_KEYS-1:0] key_cut;
        logic [`GTP_KEYS-1:0] key_auto;
        logic [`GTP_KEYS-1:0] key_take_on;
    } gtp_req_t;

endpackage : gtp_pkg

/* hdl/gtp_port.sv */
// Contact-input trigger and tally-output logic for the shared port pins, with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "gtp_map.svh"

// How it works
// - Input function none ignores the port entirely.
// - Background cut trigger requests an immediate cut.
// - Background auto trigger requests timed transition.
// - Key cut trigger requests cut of selected key.
// - Key auto toggles selected key on/off air.
// - Fade-to-black trigger requests fade to black.
// - Timecode function routes pin, ignores trigger settings.
// - Edge mode fires once per chosen transition.
// - Level mode acts and holds while level active.
// - High polarity means rising edge, high level.
// - Low polarity (default) means falling edge, low.
// - Tally makes pin output; background A tally.
// - Background B tally follows source B on-air.
// - External key tally follows external key on-air.
// - External alpha tally follows alpha on-air.
// - Numbered key tally follows that key on-air.
// - Any-key tally is OR of all keys.
// - Tally none leaves pin undriven, polarity ignored.
// - High tally polarity drives asserted pin high.
// - Low tally polarity drives asserted pin low.
module gtp_port #(
    parameter int NPORT = 4
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [NPORT-1:0] pin_i,
    output logic [NPORT-1:0] pin_o,
    output logic [NPORT-1:0] pin_oe,
    input wire gtp_pkg::gtp_on_air_t on_air,
    output gtp_pkg::gtp_req_t req,
    output logic [NPORT-1:0] level_hold,
    output logic ltc_rx,
    output logic ltc_valid,
    input wire logic [`GTP_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`GTP_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        logic [NPORT-1:0][`GTP_CFG_W-1:0] cfg;
        logic [NPORT-1:0] sync1;
        logic [NPORT-1:0] sync2;
        logic [NPORT-1:0] prev;
        logic [NPORT-1:0] lvl_act;
        logic [NPORT-1:0] pin_o;
        logic [NPORT-1:0] pin_oe;
        gtp_pkg::gtp_req_t req;
        logic ltc_rx;
        logic ltc_valid;
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [`GTP_ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } gtp_state_t;

    // Register map as software sees it over the bus.
    // Each port owns one aligned configuration word, starting at the base offset.
    // Port i sits at the base plus four times i, so the map grows with NPORT.
    // Bits two to zero choose the input function of the port.
    // Code zero is no function, and the port then has no effect at all.
    // Code one asks for a cut between the two background sources.
    // Code two asks for a timed transition between the background sources.
    // Code three asks for a cut of the key that the input key field names.
    // Code four asks for a timed transition of that key, on or off air.
    // Code five asks for a fade to black of the output.
    // Code six hands the raw pin level to the timecode receiver.
    // Code seven is not used and raises no request, but in level mode it still sets the level flag.
    // Bit three chooses edge triggering when clear and level triggering when set.
    // Bit four chooses the falling edge or low level when clear.
    // When set, it chooses the rising edge or the high level instead.
    // Bits six and five name the key that the key functions act on.
    // Bits nine to seven choose the tally function of the port.
    // Code zero is no tally, and the pin is then left to the input function.
    // Codes one and two follow the two background sources.
    // Codes three and four follow the external key and the external alpha.
    // Code five follows the key that the tally key field names.
    // Code six follows the OR of all keys.
    // Code seven drives the pin but never shows the tally as asserted.
    // Bit ten chooses the level that an asserted tally drives.
    // Clear drives the pin low when the tally is asserted, set drives it high.
    // Bits twelve and eleven name the key that the numbered key tally follows.
    // Bits above the configuration width read back as zero and ignore writes.
    // Byte lane zero writes the low eight bits, lane one the rest of the word.
    // Lanes two and three carry nothing and are ignored.
    //
    // The status word is read only.
    // Its low bits show the synchronised level of every pin.
    // The bits from the level offset up show which ports hold a level action.
    // A write to it is answered OKAY and changes nothing.
    // Any other address answers SLVERR, and a read of it returns zero.
    //
    // Timing of the pin side.
    // A pin change reaches the second synchroniser stage two edges later.
    // The request pulse then follows one edge after that.
    // A contact that bounces for less than one cycle may be lost.
    // That is the price of the synchroniser, which keeps metastable levels out.
    // Contacts are slow, so the lost pulses do not matter in practice.
    // Tally outputs follow the on-air flags one edge after they change.
    // A change of configuration also takes effect one edge after the write.
    //
    // Requests are pulses of one cycle each.
    // The switcher that takes them holds whatever state they cause.
    // Ports that share an action are ORed into one pulse.
    // Two ports that fire in one cycle thus cause only one transition.
    // For the key auto request, the take-on flag tells the direction.
    // It is set when the key was off air, so the transition brings it on.
    // It is clear when the key was on air, so the transition takes it off.
    //
    // Level mode raises one pulse when the input enters its active level.
    // It then holds the level flag until the input leaves that level.
    // Enabling level mode while the level already stands also fires once.
    // The switcher sees the flag and keeps the action in place meanwhile.
    //
    // A tally function takes the pin over as an output.
    // The input function of the same port is then set aside entirely.
    // Its level flag is cleared, so no action is held by a driven pin.
    // The pin reads back its own drive through the far side, which is harmless.
    //
    // Timing of the register bus.
    // Address and data of a write may come in either order.
    // The response rises one cycle after the later of the two is taken.
    // Both readies stay low until the response has been accepted.
    // A read is answered one cycle after its address is taken.
    // The read ready stays low until the read data has been accepted.
    // Only one write and one read are under way at any time.
    // This keeps the slave small, at the cost of a few idle cycles per access.
    // Software on this port writes rarely, so the cost does not matter.
    //
    // All state sits in one packed record that is registered as a whole.
    // The reset value of every field is zero.
    // That gives every port no input function and no tally after reset.
    gtp_state_t q;
    gtp_state_t d;

    // True when an address selects the configuration word of an existing port.
    function automatic logic cfg_hit(input logic [`GTP_ADDR_W-1:0] a);
        cfg_hit = (a[1:0] == 2'h0) && (a >= `GTP_CFG_BASE) && ((a - `GTP_CFG_BASE) < (`GTP_ADDR_W)'(NPORT * 4));
    endfunction : cfg_hit

    always_comb begin
        logic act;
        logic was;
        logic fire;
        logic tal;
        logic tpol;
        logic [`GTP_KEY_W-1:0] kn;
        logic [`GTP_ADDR_W-1:0] idx;
        gtp_pkg::gtp_in_fn_t ifn;
        gtp_pkg::gtp_tally_fn_t tfn;
        act = 1'b0;
        was = 1'b0;
        fire = 1'b0;
        tal = 1'b0;
        tpol = 1'b0;
        kn = '0;
        idx = '0;
        ifn = gtp_pkg::IN_NONE;
        tfn = gtp_pkg::TAL_NONE;
        d = q;

        // The first stage is copied only into the second; all logic below reads sync2 and prev.
        d.sync1 = pin_i;
        d.sync2 = q.sync1;
        d.prev = q.sync2;

        // Requests are single-cycle pulses; the switcher keeps whatever state they cause.
        d.req = '0;
        d.ltc_rx = 1'b0;
        d.ltc_valid = 1'b0;

        for (int i = 0; i < NPORT; i++) begin
            ifn = gtp_pkg::gtp_in_fn_t'(q.cfg[i][`GTP_IFN_MSB:`GTP_IFN_LSB]);
            tfn = gtp_pkg::gtp_tally_fn_t'(q.cfg[i][`GTP_TFN_MSB:`GTP_TFN_LSB]);
            tpol = q.cfg[i][`GTP_TPOL_BIT];
            d.pin_o[i] = 1'b0;
            d.pin_oe[i] = 1'b0;
            d.lvl_act[i] = 1'b0;

            // A tally function owns the shared pin; the input function is then set aside.
            if (tfn != gtp_pkg::TAL_NONE) begin
                kn = q.cfg[i][`GTP_TKEY_MSB:`GTP_TKEY_LSB];
                unique case (tfn)
                    gtp_pkg::TAL_BG_A: tal = on_air.bg_a;
                    gtp_pkg::TAL_BG_B: tal = on_air.bg_b;
                    gtp_pkg::TAL_EXT_KEY: tal = on_air.ext_key;
                    gtp_pkg::TAL_EXT_ALPHA: tal = on_air.ext_alpha;
                    gtp_pkg::TAL_KEY: tal = on_air.key[kn];
                    gtp_pkg::TAL_ANY_KEY: tal = |on_air.key;
                    default: tal = 1'b0;
                endcase
                d.pin_oe[i] = 1'b1;
                d.pin_o[i] = tpol ? tal : !tal;
            end else begin
                // With no tally the pin is released and the tally polarity has no effect.
                d.pin_oe[i] = 1'b0;
                kn = q.cfg[i][`GTP_IKEY_MSB:`GTP_IKEY_LSB];
                if (q.cfg[i][`GTP_IPOL_BIT]) begin
                    act = q.sync2[i];
                    was = q.prev[i];
                end else begin
                    act = !q.sync2[i];
                    was = !q.prev[i];
                end
                if (q.cfg[i][`GTP_TRIG_BIT]) begin
                    // Level mode fires on entry to the active level, also when the port is
                    // configured while the level already stands, and then holds until it changes.
                    fire = act && !q.lvl_act[i];
                end else begin
                    fire = act && !was;
                end
                unique case (ifn)
                    gtp_pkg::IN_NONE: begin
                        fire = 1'b0;
                    end
                    gtp_pkg::IN_BG_CUT: begin
                        d.req.bg_cut = d.req.bg_cut | fire;
                    end
                    gtp_pkg::IN_BG_AUTO: begin
                        d.req.bg_auto = d.req.bg_auto | fire;
                    end
                    gtp_pkg::IN_KEY_CUT: begin
                        d.req.key_cut[kn] = d.req.key_cut[kn] | fire;
                    end
                    gtp_pkg::IN_KEY_AUTO: begin
                        d.req.key_auto[kn] = d.req.key_auto[kn] | fire;
                        d.req.key_take_on[kn] = d.req.key_take_on[kn] | (fire && !on_air.key[kn]);
                    end
                    gtp_pkg::IN_FADE_BLACK: begin
                        d.req.fade_black = d.req.fade_black | fire;
                    end
                    gtp_pkg::IN_TIMECODE: begin
                        // Raw pin level, with trigger and polarity settings bypassed.
                        d.ltc_rx = d.ltc_rx | q.sync2[i];
                        d.ltc_valid = 1'b1;
                        fire = 1'b0;
                    end
                    default: begin
                        fire = 1'b0;
                    end
                endcase
                d.lvl_act[i] = q.cfg[i][`GTP_TRIG_BIT] && act && (ifn != gtp_pkg::IN_NONE)
                    && (ifn != gtp_pkg::IN_TIMECODE);
            end
        end

        // Write path: address and data are taken in either order, the response follows both.
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (d.aw_have && d.w_have && !d.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `GTP_RESP_OKAY;
            if (cfg_hit(d.awaddr)) begin
                idx = (d.awaddr - `GTP_CFG_BASE) >> 2;
                for (int i = 0; i < NPORT; i++) begin
                    if (idx == (`GTP_ADDR_W)'(i)) begin
                        if (d.wstrb[0]) begin
                            d.cfg[i][7:0] = d.wdata[7:0];
                        end
                        if (d.wstrb[1]) begin
                            d.cfg[i][`GTP_CFG_W-1:8] = d.wdata[`GTP_CFG_W-1:8];
                        end
                    end
                end
            end else if (d.awaddr != `GTP_STAT_OFF) begin
                d.bresp = `GTP_RESP_SLVERR;
            end
        end
        // Ready is registered, so a new beat is refused while one is held or a response waits.
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        // Read path: one read under way, answered in the cycle after the address is taken.
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = `GTP_RESP_OKAY;
            d.rdata = '0;
            if (cfg_hit(s_axi_araddr)) begin
                idx = (s_axi_araddr - `GTP_CFG_BASE) >> 2;
                for (int i = 0; i < NPORT; i++) begin
                    if (idx == (`GTP_ADDR_W)'(i)) begin
                        d.rdata[`GTP_CFG_W-1:0] = q.cfg[i];
                    end
                end
            end else if (s_axi_araddr == `GTP_STAT_OFF) begin
                d.rdata[NPORT-1:0] = q.sync2;
                d.rdata[`GTP_LVL_LSB +: NPORT] = q.lvl_act;
            end else begin
                d.rresp = `GTP_RESP_SLVERR;
            end
        end
        d.arready = !d.rvalid;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_o = q.pin_o;
    assign pin_oe = q.pin_oe;
    assign req = q.req;
    assign level_hold = q.lvl_act;
    assign ltc_rx = q.ltc_rx;
    assign ltc_valid = q.ltc_valid;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bresp = q.bresp;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rvalid = q.rvalid;

endmodule : gtp_port

/* tb/gtp_contacts.sv */
// Far-side model: pulled-up contact closures sharing each pin with a tally lamp.
`timescale 1ns/1ps
module gtp_contacts #(
    parameter int N = 4
) (
    input wire logic [N-1:0] contact,
    input wire logic [N-1:0] pin_o,
    input wire logic [N-1:0] pin_oe,
    output logic [N-1:0] pin_i
);
    // A driven pin shows the port's level, so a tally port reads back its own lamp.
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & contact);
endmodule : gtp_contacts

/* tb/gtp_port_asserts.sv */
// Concurrent checks on the port block's pins, requests and register bus.
`timescale 1ns/1ps
module gtp_port_asserts #(
    parameter int NPORT = 4
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [NPORT-1:0] pin_o,
    input wire logic [NPORT-1:0] pin_oe,
    input wire gtp_pkg::gtp_req_t req,
    input wire logic ltc_rx,
    input wire logic ltc_valid,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    chk_idle_pin: assert property ((pin_o & ~pin_oe) == '0)
        else $error("released pin driven");
    chk_cut_pulse: assert property (req.bg_cut |=> !req.bg_cut)
        else $error("cut request longer than one cycle");
    chk_fade_pulse: assert property ($rose(req.fade_black) |=> $fell(req.fade_black))
        else $error("fade request longer than one cycle");
    chk_take_dir: assert property ((req.key_take_on & ~req.key_auto) == '0)
        else $error("take-on without key auto");
    chk_ltc_gate: assert property (ltc_rx |-> ltc_valid)
        else $error("timecode without timecode port");
    chk_b_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    chk_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    cover property (req.bg_cut);
    cover property (|pin_oe);
    cover property (ltc_valid);
endmodule : gtp_port_asserts

bind gtp_port gtp_port_asserts #(.NPORT(NPORT)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .pin_o(pin_o),
    .pin_oe(pin_oe), .req(req), .ltc_rx(ltc_rx), .ltc_valid(ltc_valid), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid));

/* tb/gtp_port_tb_top.sv */
// Self-checking bench for the contact-input and tally port block.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module gtp_port_tb_top;
    logic ref_clk = 0;
    logic reset_n = 0;
    logic [3:0] contact = 4'hF;
    logic [3:0] pin_i, pin_o, pin_oe, level_hold;
    logic [7:0] air = 8'h00;
    gtp_pkg::gtp_req_t req, acc;
    logic ltc_rx, ltc_valid, e;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [14:0] ereq [5] = '{15'h4000, 15'h2000, 15'h0200, 15'h0022, 15'h1000};
    int failures = 0, checked = 0, np, cyc = 0;
    always #2 ref_clk = ~ref_clk;
    gtp_contacts u_far (.contact(contact), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
    gtp_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .on_air(gtp_pkg::gtp_on_air_t'(air)), .req(req), .level_hold(level_hold), .ltc_rx(ltc_rx),
        .ltc_valid(ltc_valid), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        awaddr <= a;
        awvalid <= 1;
        wdata <= v;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        r = bresp;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        d = rdata;
        r = rresp;
    endtask : rd
    task pin(input logic [3:0] v);
        @(posedge ref_clk);
        contact <= v;
    endtask : pin
    // Sampling 1 ns after the edge keeps the count clear of the edge's own updates.
    task watch(input int n);
        acc = '0;
        np = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            acc = acc | req;
            if (req !== '0) np++;
        end
    endtask : watch
    task note(input string s);
        $display("test %s done, failures %0d", s, failures);
    endtask : note
    task test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1;
        rd(8'h00);
        `CHK(d, 32'h0)
        `CHK(pin_oe, 4'h0)
        rd(8'h80);
        `CHK(r, 2'h2)
        wr(8'h80, 32'h1);
        `CHK(r, 2'h2)
        note("reset");
        wr(8'h00, 32'h1);
        `CHK(r, 2'h0)
        pin(4'hE);
        watch(6);
        `CHK(acc, 15'h4000)
        `CHK(np, 1)
        pin(4'hF);
        watch(6);
        `CHK(np, 0)
        note("edge");
        for (int f = 1; f <= 5; f++) begin
            wr(8'h00, 32'h30 | f);
            pin(4'hE);
            watch(6);
            `CHK(np, 0)
            pin(4'hF);
            watch(6);
            `CHK(acc, ereq[f-1])
            `CHK(np, 1)
        end
        note("functions");
        wr(8'h00, 32'h9);
        pin(4'hE);
        watch(6);
        `CHK(np, 1)
        `CHK(level_hold, 4'h1)
        rd(8'h40);
        `CHK(d, 32'h0001000E)
        watch(8);
        `CHK(np, 0)
        pin(4'hF);
        watch(4);
        `CHK(level_hold, 4'h0)
        wr(8'h00, 32'h18);
        pin(4'hE);
        watch(6);
        `CHK(np, 0)
        pin(4'hF);
        watch(6);
        `CHK(np + level_hold, 0)
        note("level");
        wr(8'h04, 32'h1E);
        pin(4'hD);
        watch(4);
        `CHK(ltc_valid, 1'b1)
        `CHK(ltc_rx | (np != 0), 1'b0)
        pin(4'hF);
        watch(4);
        `CHK(ltc_rx, 1'b1)
        note("timecode");
        for (int f = 1; f <= 6; f++) begin
            for (int p = 0; p < 2; p++) begin
                wr(8'h08, (f << 7) | (p << 10) | 32'h1000);
                for (int i = 0; i < 8; i++) begin
                    @(posedge ref_clk);
                    air <= 8'h01 << i;
                    watch(3);
                    e = (f < 5) ? (i == 8 - f) : (f == 5) ? (i == 2) : (i < 4);
                    `CHK(pin_oe[2], 1'b1)
                    `CHK(pin_o[2], e == p)
                end
            end
        end
        wr(8'h08, 32'h400);
        watch(3);
        `CHK(pin_oe[2], 1'b0)
        rd(8'h08);
        `CHK(d, 32'h400)
        note("tally");
        test_done();
    end
endmodule : gtp_port_tb_top
